//--- rtl/rtcsta_top.sv
/*
  Calendar shadow registers with read locking and bypass, falling-edge tamper
  detection with erase control, and alarm A/B flags OR-ed onto one line flag.
  Assumes read strobes, the update pulse and the configuration come from the
  same clock domain; the tamper pins and alarm events are asynchronous.
*/
// Behaviour
// - With bypass off, a subsecond read freezes the time and date copies.
// - With bypass off, a time read keeps the date copy locked.
// - A subsecond or time read in the same cycle as an update escapes the lock; known defect flagged.
// - With bypass set to 1, reads return the live calendar values.
// - Filter 00 and polarity 1 detect tamper events on a falling input edge.
// - Clearing enable in falling mode while the input is high makes an event.
// - With no-erase set, a tamper event is flagged but erases nothing.
// - Alarm A and alarm B flags are OR-ed onto one interrupt line flag.
// - Line flag clears after a delay; an alarm in that window is lost.
`timescale 1ns/1ps
`default_nettype none
module rtcsta_top (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_SHADOW_BYPASS,
  input wire logic I_SHADOW_UPDATE,
  input wire rtcsta_pkg::rtcsta_cal_t I_LIVE,
  input wire rtcsta_pkg::rtcsta_rd_t I_RD,
  output logic [rtcsta_pkg::RTCSTA_SS_W-1:0] O_SUBSECOND_REG,
  output logic [rtcsta_pkg::RTCSTA_TR_W-1:0] O_TIME_REG,
  output logic [rtcsta_pkg::RTCSTA_DR_W-1:0] O_DATE_REG,
  output logic O_LOCK_DEFECT,
  input wire rtcsta_pkg::rtcsta_tcfg_t I_TCFG,
  input wire logic [rtcsta_pkg::RTCSTA_NTAMP-1:0] I_TAMPER_PIN,
  input wire logic [rtcsta_pkg::RTCSTA_NTAMP-1:0] I_TAMPER_FLAG_CLR,
  output logic [rtcsta_pkg::RTCSTA_NTAMP-1:0] O_TAMPER_FLAG,
  output logic O_BACKUP_ERASE,
  input wire logic I_ALARM_A_EVT,
  input wire logic I_ALARM_B_EVT,
  input wire logic I_ALARM_A_CLR,
  input wire logic I_ALARM_B_CLR,
  input wire logic I_LINE_CLR,
  output logic O_ALARM_A_FLAG,
  output logic O_ALARM_B_FLAG,
  output logic O_LINE_FLAG
);
  import rtcsta_pkg::*;

  // ==========================================================================
  // Shadow copies and read lock.
  rtcsta_lock_t lock_q, lock_d;
  rtcsta_cal_t shd_q, shd_d;
  logic [RTCSTA_SS_W-1:0] ss_q, ss_d;
  logic [RTCSTA_TR_W-1:0] tr_q, tr_d;
  logic [RTCSTA_DR_W-1:0] dr_q, dr_d;
  logic defect_q, defect_d;

  // The update is held off while locked; a read landing in the same cycle
  // as an update still lets that update through, as silicon does.
  always_comb begin
    lock_d = lock_q;
    shd_d = shd_q;
    ss_d = ss_q;
    tr_d = tr_q;
    dr_d = dr_q;
    defect_d = 1'b0;
    if (I_SHADOW_UPDATE && (lock_q == RTCSTA_OPEN)) begin
      shd_d = I_LIVE;
    end
    if (I_RD.rd_ss) begin
      ss_d = I_SHADOW_BYPASS ? I_LIVE.ss : shd_q.ss;
      if (!I_SHADOW_BYPASS) begin
        lock_d = RTCSTA_LK_SS;
      end
    end
    if (I_RD.rd_tr) begin
      tr_d = I_SHADOW_BYPASS ? I_LIVE.tr : shd_q.tr;
      if (!I_SHADOW_BYPASS) begin
        lock_d = RTCSTA_LK_TR;
      end
    end
    if (I_RD.rd_dr) begin
      dr_d = I_SHADOW_BYPASS ? I_LIVE.dr : shd_q.dr;
      lock_d = RTCSTA_OPEN;
    end
    // A read taken while an update lands in the same cycle sees the old copy
    // yet the copy moves under it: the lock arrives one cycle too late.
    if ((I_RD.rd_ss || I_RD.rd_tr) && !I_SHADOW_BYPASS && I_SHADOW_UPDATE && (lock_q == RTCSTA_OPEN)) begin
      defect_d = 1'b1;
    end
    if (I_SHADOW_BYPASS) begin
      lock_d = RTCSTA_OPEN;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      lock_q <= RTCSTA_OPEN;
      shd_q <= '{ss: RTCSTA_SS_RST, tr: RTCSTA_TR_RST, dr: RTCSTA_DR_RST};
      ss_q <= RTCSTA_SS_RST;
      tr_q <= RTCSTA_TR_RST;
      dr_q <= RTCSTA_DR_RST;
      defect_q <= 1'b0;
    end else begin
      lock_q <= lock_d;
      shd_q <= shd_d;
      ss_q <= ss_d;
      tr_q <= tr_d;
      dr_q <= dr_d;
      defect_q <= defect_d;
    end
  end

  assign O_SUBSECOND_REG = ss_q;
  assign O_TIME_REG = tr_q;
  assign O_DATE_REG = dr_q;
  assign O_LOCK_DEFECT = defect_q;

  // ==========================================================================
  // Tamper channels.
  logic [RTCSTA_NTAMP-1:0] tp_s1_q, tp_s2_q, tp_s3_q;
  logic [RTCSTA_NTAMP-1:0] en_prev_q;
  logic [RTCSTA_NTAMP-1:0] tflag_q, tflag_d;
  logic erase_q, erase_d;

  // Detection ORs the enabled falling pin edge with a fall of enable, so dropping
  // enable while the pin is high looks exactly like a falling edge.
  always_comb begin
    logic [RTCSTA_NTAMP-1:0] evt;
    logic edge_mode;
    evt = '0;
    edge_mode = (I_TCFG.filter == RTCSTA_FLT_EDGE);
    tflag_d = tflag_q;
    erase_d = 1'b0;
    for (int i = 0; i < RTCSTA_NTAMP; i++) begin
      if (edge_mode && I_TCFG.polarity[i] == RTCSTA_POL_FALL) begin
        evt[i] = (I_TCFG.enable[i] && tp_s3_q[i] && !tp_s2_q[i])
                 || (en_prev_q[i] && !I_TCFG.enable[i] && tp_s2_q[i]);
      end
      if (I_TAMPER_FLAG_CLR[i]) begin
        tflag_d[i] = 1'b0;
      end
      if (evt[i]) begin
        tflag_d[i] = 1'b1;
        if (!I_TCFG.no_erase[i]) begin
          erase_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      tp_s1_q <= '0;
      tp_s2_q <= '0;
      tp_s3_q <= '0;
      en_prev_q <= '0;
      tflag_q <= '0;
      erase_q <= 1'b0;
    end else begin
      tp_s1_q <= I_TAMPER_PIN;
      tp_s2_q <= tp_s1_q;
      tp_s3_q <= tp_s2_q;
      en_prev_q <= I_TCFG.enable;
      tflag_q <= tflag_d;
      erase_q <= erase_d;
    end
  end

  assign O_TAMPER_FLAG = tflag_q;
  assign O_BACKUP_ERASE = erase_q;

  // ==========================================================================
  // Alarm flags and shared line flag.
  logic [1:0] aa_s_q, ab_s_q;
  logic aa_prev_q, ab_prev_q;
  logic af_q, af_d, bf_q, bf_d;
  logic line_q, line_d;
  logic or_prev_q;
  logic [3:0] lclr_q, lclr_d;

  // The line is edge-sensitive on the OR of both flags; a rising edge during
  // the pending clear is swallowed when the delayed clear fires.
  always_comb begin
    logic aev, bev, or_now;
    aev = aa_s_q[1] && !aa_prev_q;
    bev = ab_s_q[1] && !ab_prev_q;
    or_now = af_q || bf_q;
    af_d = af_q;
    bf_d = bf_q;
    if (I_ALARM_A_CLR) af_d = 1'b0;
    if (aev) af_d = 1'b1;
    if (I_ALARM_B_CLR) bf_d = 1'b0;
    if (bev) bf_d = 1'b1;
    line_d = line_q;
    lclr_d = lclr_q;
    if (or_now && !or_prev_q) begin
      line_d = 1'b1;
    end
    if (I_LINE_CLR) begin
      lclr_d = RTCSTA_LCLR_CYC;
    end else if (lclr_q != RTCSTA_CNT_ZERO) begin
      lclr_d = lclr_q - RTCSTA_CNT_ONE;
      if (lclr_q == RTCSTA_CNT_ONE) begin
        line_d = 1'b0;
      end
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      aa_s_q <= 2'h0;
      ab_s_q <= 2'h0;
      aa_prev_q <= 1'b0;
      ab_prev_q <= 1'b0;
      af_q <= 1'b0;
      bf_q <= 1'b0;
      line_q <= 1'b0;
      or_prev_q <= 1'b0;
      lclr_q <= RTCSTA_CNT_ZERO;
    end else begin
      aa_s_q <= {aa_s_q[0], I_ALARM_A_EVT};
      ab_s_q <= {ab_s_q[0], I_ALARM_B_EVT};
      aa_prev_q <= aa_s_q[1];
      ab_prev_q <= ab_s_q[1];
      af_q <= af_d;
      bf_q <= bf_d;
      line_q <= line_d;
      or_prev_q <= af_q || bf_q;
      lclr_q <= lclr_d;
    end
  end

  assign O_ALARM_A_FLAG = af_q;
  assign O_ALARM_B_FLAG = bf_q;
  assign O_LINE_FLAG = line_q;

  // ==========================================================================
  // Assertions.
  property p_bypass_live;
    @(posedge I_MCLK) disable iff (I_RST)
      (I_RD.rd_ss && I_SHADOW_BYPASS) |=> (O_SUBSECOND_REG == $past(I_LIVE.ss));
  endproperty
  a_bypass_live: assert property (p_bypass_live) else $error("bypass read not live");

  property p_ss_locks;
    @(posedge I_MCLK) disable iff (I_RST)
      (I_RD.rd_ss && !I_SHADOW_BYPASS && !I_RD.rd_tr && !I_RD.rd_dr) |=> (lock_q == RTCSTA_LK_SS);
  endproperty
  a_ss_locks: assert property (p_ss_locks) else $error("subsecond read did not lock");

  property p_locked_hold;
    @(posedge I_MCLK) disable iff (I_RST)
      (lock_q != RTCSTA_OPEN) |=> $stable(shd_q);
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("shadow changed while locked");

  property p_dr_release;
    @(posedge I_MCLK) disable iff (I_RST)
      I_RD.rd_dr |=> (lock_q == RTCSTA_OPEN);
  endproperty
  a_dr_release: assert property (p_dr_release) else $error("date read did not release");

  property p_defect;
    @(posedge I_MCLK) disable iff (I_RST)
      (I_RD.rd_ss && !I_SHADOW_BYPASS && I_SHADOW_UPDATE && lock_q == RTCSTA_OPEN) |=> O_LOCK_DEFECT;
  endproperty
  a_defect: assert property (p_defect) else $error("lock defect not flagged");

  property p_no_erase;
    @(posedge I_MCLK) disable iff (I_RST)
      ((I_TCFG.no_erase == '1) && $past(I_TCFG.no_erase == '1)) |=> !O_BACKUP_ERASE;
  endproperty
  a_no_erase: assert property (p_no_erase) else $error("erase despite no-erase");

  property p_spurious;
    @(posedge I_MCLK) disable iff (I_RST)
      (I_TCFG.filter == RTCSTA_FLT_EDGE && I_TCFG.polarity[RTCSTA_NTAMP-1] && en_prev_q[RTCSTA_NTAMP-1]
       && !I_TCFG.enable[RTCSTA_NTAMP-1] && tp_s2_q[RTCSTA_NTAMP-1] && !I_TAMPER_FLAG_CLR[RTCSTA_NTAMP-1])
       |=> O_TAMPER_FLAG[RTCSTA_NTAMP-1];
  endproperty
  a_spurious: assert property (p_spurious) else $error("no spurious tamper event");

  sequence s_or_rise;
    !or_prev_q && (af_q || bf_q) && !(lclr_q == RTCSTA_CNT_ONE && !I_LINE_CLR);
  endsequence
  property p_line_set;
    @(posedge I_MCLK) disable iff (I_RST)
      s_or_rise |=> O_LINE_FLAG;
  endproperty
  a_line_set: assert property (p_line_set) else $error("line flag not set");

  property p_line_clr;
    @(posedge I_MCLK) disable iff (I_RST)
      (I_LINE_CLR ##1 !I_LINE_CLR [*3]) |=> !O_LINE_FLAG || $rose(O_LINE_FLAG);
  endproperty
  a_line_clr: assert property (p_line_clr) else $error("line flag not cleared in time");
endmodule // rtcsta_top
`default_nettype wire

//--- shared/rtcsta_pkg.sv
/*
  Package of the shadow, tamper and alarm block: widths, field layouts,
  timing counts, state encodings and the packed carriers of the top module.
  Assumes a single 20 MHz clock domain.
*/
`default_nettype none
package rtcsta_pkg;
  // ==========================================================================
  // Widths and constants.
  localparam int RTCSTA_SS_W = 16;
  localparam int RTCSTA_TR_W = 23;
  localparam int RTCSTA_DR_W = 24;
  localparam int RTCSTA_NTAMP = 3;
  localparam logic [1:0] RTCSTA_FLT_EDGE = 2'h0;
  localparam logic RTCSTA_POL_FALL = 1'h1;
  localparam logic [RTCSTA_SS_W-1:0] RTCSTA_SS_RST = 16'h0000;
  localparam logic [RTCSTA_TR_W-1:0] RTCSTA_TR_RST = 23'h000000;
  localparam logic [RTCSTA_DR_W-1:0] RTCSTA_DR_RST = 24'h000000;
  // Delay of the hardware clear of the line flag after the software clear.
  localparam int RTCSTA_CLK_NS = 50;
  localparam int RTCSTA_LCLR_NS = 150;
  localparam int RTCSTA_LCLR_CYC_I = (RTCSTA_LCLR_NS / RTCSTA_CLK_NS) < 1 ? 1 : (RTCSTA_LCLR_NS / RTCSTA_CLK_NS);
  localparam logic [3:0] RTCSTA_LCLR_CYC = 4'(RTCSTA_LCLR_CYC_I);
  localparam logic [3:0] RTCSTA_CNT_ZERO = 4'h0;
  localparam logic [3:0] RTCSTA_CNT_ONE = 4'h1;

  // ==========================================================================
  // Shadow lock states.
  typedef enum logic [2:0] {
    RTCSTA_OPEN = 3'h1,
    RTCSTA_LK_SS = 3'h2,
    RTCSTA_LK_TR = 3'h4
  } rtcsta_lock_t;

  // Live calendar values from the calendar counter.
  typedef struct packed {
    logic [RTCSTA_SS_W-1:0] ss;
    logic [RTCSTA_TR_W-1:0] tr;
    logic [RTCSTA_DR_W-1:0] dr;
  } rtcsta_cal_t;

  // Tamper configuration: per-channel enable, polarity and no-erase; one filter shared by all channels.
  typedef struct packed {
    logic [RTCSTA_NTAMP-1:0] enable;
    logic [RTCSTA_NTAMP-1:0] polarity;
    logic [RTCSTA_NTAMP-1:0] no_erase;
    logic [1:0] filter;
  } rtcsta_tcfg_t;

  // Calendar read strobes, one cycle each.
  typedef struct packed {
    logic rd_ss;
    logic rd_tr;
    logic rd_dr;
  } rtcsta_rd_t;
endpackage
`default_nettype wire

//--- verif/rtcsta_cal_src.sv
/*
  Calendar source model for the shadow block: a live calendar that moves
  every cycle and a one-cycle shadow refresh pulse every fourth cycle.
  Assumes one clock domain and an active-high asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcsta_cal_src (
  input wire logic i_clk,
  input wire logic i_rst,
  output var rtcsta_pkg::rtcsta_cal_t o_live,
  output logic o_upd
);
  import rtcsta_pkg::*;
  logic [1:0] ph_q;
  // ==========================================================================
  // The live count moves every cycle, so a frozen copy is always visibly stale.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_live <= '0;
      ph_q <= 2'h0;
    end else begin
      o_live.ss <= o_live.ss + 16'h0001;
      o_live.tr <= o_live.tr + 23'h000003;
      o_live.dr <= o_live.dr + 24'h000005;
      ph_q <= ph_q + 2'h1;
    end
  end
  // The refresh pulse rises on every fourth phase.
  assign o_upd = (ph_q == 2'h3);
endmodule // rtcsta_cal_src
`default_nettype wire

//--- verif/tb_top.sv
/*
  Self-checking testbench of the shadow, tamper and alarm block.
  Assumes the calendar source model feeds the live calendar and refresh pulse.
*/
`timescale 1ns/1ps
`default_nettype none
`define TB_CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, act, exp); end end
module tb_top;
  import rtcsta_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic byp = 1'b0;
  logic upd;
  logic lk = 1'b0;
  rtcsta_cal_t live;
  rtcsta_cal_t sh = '0;
  rtcsta_cal_t exp_c;
  rtcsta_rd_t rd_s = '0;
  rtcsta_tcfg_t tcfg = '{enable: 3'h7, polarity: 3'h7, no_erase: 3'h2, filter: 2'h0};
  logic [2:0] pin = 3'h7;
  logic [2:0] tclr = 3'h0;
  logic aev = 1'b0, bev = 1'b0, acl = 1'b0, bcl = 1'b0, lcl = 1'b0;
  logic [15:0] ss;
  logic [22:0] tr;
  logic [23:0] dr;
  logic [2:0] tflag, sf;
  logic defect, erase, af, bf, lf, se, sd;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int seed = 8;
  int k;

  // ==========================================================================
  // Clock and instances.
  always #25 clk = ~clk;
  rtcsta_cal_src src (.i_clk(clk), .i_rst(rst), .o_live(live), .o_upd(upd));
  rtcsta_top dut (.I_MCLK(clk), .I_RST(rst), .I_SHADOW_BYPASS(byp), .I_SHADOW_UPDATE(upd), .I_LIVE(live),
    .I_RD(rd_s), .O_SUBSECOND_REG(ss), .O_TIME_REG(tr), .O_DATE_REG(dr), .O_LOCK_DEFECT(defect),
    .I_TCFG(tcfg), .I_TAMPER_PIN(pin), .I_TAMPER_FLAG_CLR(tclr), .O_TAMPER_FLAG(tflag),
    .O_BACKUP_ERASE(erase), .I_ALARM_A_EVT(aev), .I_ALARM_B_EVT(bev), .I_ALARM_A_CLR(acl),
    .I_ALARM_B_CLR(bcl), .I_LINE_CLR(lcl), .O_ALARM_A_FLAG(af), .O_ALARM_B_FLAG(bf), .O_LINE_FLAG(lf));

  // ==========================================================================
  // Expected shadow copies: refreshed only while unlocked, so frozen data is predicted.
  always @(posedge clk) begin
    if (upd && !lk) sh <= live;
    if ((rd_s.rd_ss || rd_s.rd_tr) && !byp) lk <= 1'b1;
    if (rd_s.rd_dr || byp) lk <= 1'b0;
  end
  // Pulses are short, so they are gathered into sticky seen-bits; a hang is cut off.
  always @(posedge clk) begin
    sf |= tflag;
    se |= erase;
    sd |= defect;
    cyc++;
    if (cyc == 3000) begin
      errors++;
      end_of_test();
    end
  end

  function automatic logic [23:0] pick(input int sel, input rtcsta_cal_t c);
    return (sel == 0) ? 24'(c.ss) : (sel == 1) ? 24'(c.tr) : c.dr;
  endfunction
  // Reads are started right after a refresh so the take edge never meets one.
  task automatic rd_cal(input int sel);
    do @(posedge clk); while (upd !== 1'b1);
    rd_s <= rtcsta_rd_t'(3'h4 >> sel);
    @(posedge clk);
    exp_c = byp ? live : sh;
    rd_s <= '0;
    @(negedge clk);
  endtask
  task automatic win(input int n);
    @(negedge clk);
    sf = 3'h0;
    se = 1'b0;
    sd = 1'b0;
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic end_of_test();
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    byp <= 1'b1;
    repeat (12) begin
      k = $unsigned($random(seed)) % 3;
      rd_cal(k);
      `TB_CHK(pick(k, rtcsta_cal_t'({ss, tr, dr})), pick(k, exp_c))
    end
    @(posedge clk);
    byp <= 1'b0;
    rd_cal(0);
    `TB_CHK(ss, exp_c.ss)
    repeat (9) @(posedge clk);
    rd_cal(1);
    `TB_CHK(tr, exp_c.tr)
    repeat (5) @(posedge clk);
    rd_cal(2);
    `TB_CHK(dr, exp_c.dr)
    // Software rereads the subsecond after the three reads; a refresh has moved it.
    rd_cal(0);
    `TB_CHK(ss, exp_c.ss)
    rd_cal(2);
    // A read whose take edge meets a refresh must raise the defect flag.
    do @(posedge clk); while (upd !== 1'b1);
    repeat (3) @(posedge clk);
    rd_s <= '{rd_ss: 1'b1, rd_tr: 1'b0, rd_dr: 1'b0};
    @(posedge clk);
    rd_s <= '0;
    win(3);
    `TB_CHK(sd, 1'b1)
    rd_cal(2);
    // A time read alone must keep the date copy frozen across refreshes.
    rd_cal(1);
    repeat (6) @(posedge clk);
    rd_cal(2);
    `TB_CHK(dr, exp_c.dr)
    // Tamper: a plain falling edge, one on a channel that must not erase, then an enable drop with the pin high.
    @(posedge clk);
    pin <= 3'h6;
    win(8);
    `TB_CHK(sf, 3'h1)
    `TB_CHK(se, 1'b1)
    @(posedge clk);
    tclr <= 3'h7;
    pin <= 3'h4;
    @(posedge clk);
    tclr <= 3'h0;
    win(8);
    `TB_CHK(sf, 3'h2)
    `TB_CHK(se, 1'b0)
    @(posedge clk);
    tclr <= 3'h7;
    tcfg.no_erase <= 3'h7;
    @(posedge clk);
    tclr <= 3'h0;
    tcfg.enable <= 3'h3;
    win(8);
    `TB_CHK(sf, 3'h4)
    `TB_CHK(se, 1'b0)
    // Alarms: each source raises the shared line; clearing drops it after a delay.
    @(posedge clk);
    aev <= 1'b1;
    win(8);
    `TB_CHK({af, lf}, 2'h3)
    @(posedge clk);
    acl <= 1'b1;
    lcl <= 1'b1;
    @(posedge clk);
    acl <= 1'b0;
    lcl <= 1'b0;
    win(8);
    `TB_CHK({af, lf}, 2'h0)
    @(posedge clk);
    bev <= 1'b1;
    win(8);
    `TB_CHK({bf, lf}, 2'h3)
    @(posedge clk);
    aev <= 1'b0;
    bcl <= 1'b1;
    @(posedge clk);
    bcl <= 1'b0;
    repeat (4) @(posedge clk);
    aev <= 1'b1;
    @(posedge clk);
    lcl <= 1'b1;
    @(posedge clk);
    lcl <= 1'b0;
    win(10);
    `TB_CHK({af, lf}, 2'h2)
    // Service after the line clear: clearing alarm A leaves both alarm flags and the line low; the lost event stays unseen.
    @(posedge clk);
    acl <= 1'b1;
    @(posedge clk);
    acl <= 1'b0;
    win(4);
    `TB_CHK({af, bf, lf}, 3'h0)
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
